// ---- hw/tms_pkg.sv ----
// constants, command codes and carrier types of the temperature monitor status and serial slave
package tms_pkg;
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a;   // arbitrary default slave address
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [7:0] CMD_LOCAL = 8'h00;
   localparam logic [7:0] CMD_REMOTE = 8'h01;
   localparam logic [7:0] CMD_STATUS = 8'h02;
   localparam logic [7:0] CMD_CFG_RD = 8'h03;
   localparam logic [7:0] CMD_RATE_RD = 8'h04;
   localparam logic [7:0] CMD_LHI_RD = 8'h05;
   localparam logic [7:0] CMD_LLO_RD = 8'h06;
   localparam logic [7:0] CMD_RHI_RD = 8'h07;
   localparam logic [7:0] CMD_RLO_RD = 8'h08;
   localparam logic [7:0] CMD_CFG_WR = 8'h09;
   localparam logic [7:0] CMD_RATE_WR = 8'h0a;
   localparam logic [7:0] CMD_LHI_WR = 8'h0b;
   localparam logic [7:0] CMD_LLO_WR = 8'h0c;
   localparam logic [7:0] CMD_RHI_WR = 8'h0d;
   localparam logic [7:0] CMD_RLO_WR = 8'h0e;
   localparam logic [7:0] CMD_ONESHOT = 8'h0f;
   localparam logic [7:0] RST_PTR = 8'h00;
   localparam logic [2:0] RST_RATE = 3'h2;
   localparam logic [7:0] RST_HIGH = 8'h7f;
   localparam logic [7:0] RST_LOW = 8'hc9;
   localparam logic [7:0] RST_TEMP = 8'h00;
   localparam logic [7:0] TEMP_FAULT = 8'h7f;
   localparam logic [4:0] RST_FLAGS = 5'h00;
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_STBY_BIT = 6;
   localparam int FL_LHI = 4;
   localparam int FL_LLO = 3;
   localparam int FL_RHI = 2;
   localparam int FL_RLO = 1;
   localparam int FL_OPEN = 0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_PRE = 4'hf;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_CMD    = 3'b010,
      ST_WDATA  = 3'b011,
      ST_READ   = 3'b100,
      ST_IGNORE = 3'b101
   } tms_state_t;

   typedef struct packed {
      logic [7:0] local_temp;
      logic [7:0] remote_temp;
      logic       diode_open;
      logic       diode_shorted;
   } tms_conv_t;

   typedef struct packed {
      logic [7:0] local_high;
      logic [7:0] local_low;
      logic [7:0] remote_high;
      logic [7:0] remote_low;
   } tms_limits_t;
endpackage

// ---- hw/tms_sync.sv ----
// two flip-flop synchroniser for the serial clock and data pins
`timescale 1ns/100ps
module tms_sync (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // pin levels in, synchronised levels out
   input  wire logic [1:0] pin_in,
   output logic      [1:0] pin_sync
);
   logic [1:0] stage1;
   logic [1:0] next_stage1;
   logic [1:0] next_pin_sync;

   always_comb begin
      next_stage1 = pin_in;
      next_pin_sync = stage1;
   end

   // idle bus is high, so both stages reset high to avoid a false start
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 2'h3;
         pin_sync <= 2'h3;
      end else begin
         stage1 <= next_stage1;
         pin_sync <= next_pin_sync;
      end
   end
endmodule // tms_sync

// ---- hw/tms_top.sv ----
// status flags, latched alert with alert response, and byte protocol serial slave
`timescale 1ns/100ps
module tms_top #(
   parameter logic [6:0] DEV_ADDR = tms_pkg::DEV_ADDR_DFLT
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // serial bus pins
   input  wire logic              scl_in,
   input  wire logic              serial_data_pin_in,
   output logic                   serial_data_pin_out,
   output logic                   serial_data_pin_oe,
   // alert pin, open drain
   output logic                   alert_n_out,
   output logic                   alert_n_oe,
   // conversion engine
   input  wire logic              auto_tick,
   input  wire logic              conv_done,
   input  wire tms_pkg::tms_conv_t conv,
   output logic                   conv_start,
   output logic                   standby,
   output logic [2:0]             conv_rate
);
   logic [1:0]           pins_sync;
   logic                 scl_s;
   logic                 sda_s;
   logic                 scl_d;
   logic                 sda_d;
   tms_pkg::tms_state_t  state;
   tms_pkg::tms_state_t  after;
   logic [3:0]           bit_cnt;
   logic [7:0]           shift;
   logic [7:0]           tx;
   logic                 is_ara;
   logic                 send_ok;
   logic [7:0]           cmd_ptr;
   logic                 cfg_mask;
   tms_pkg::tms_limits_t lim;
   logic [7:0]           local_temp_reading;
   logic [7:0]           remote_temp_reading;
   logic [4:0]           flags;
   logic [4:0]           cond;
   logic                 busy;
   logic                 fault_seen;
   logic                 fault_open;
   logic                 alert_latch;

   tms_pkg::tms_state_t  next_state;
   tms_pkg::tms_state_t  next_after;
   logic [3:0]           next_bit_cnt;
   logic [7:0]           next_shift;
   logic [7:0]           next_tx;
   logic                 next_is_ara;
   logic                 next_send_ok;
   logic [7:0]           next_cmd_ptr;
   logic                 next_cfg_mask;
   logic                 next_standby;
   logic [2:0]           next_conv_rate;
   tms_pkg::tms_limits_t next_lim;
   logic [7:0]           next_local;
   logic [7:0]           next_remote;
   logic [4:0]           next_flags;
   logic [4:0]           next_cond;
   logic                 next_busy;
   logic                 next_fault_seen;
   logic                 next_fault_open;
   logic                 next_alert_latch;
   logic                 next_alert_oe;
   logic                 next_sda_oe;
   logic                 next_conv_start;
   logic                 rise;
   logic                 fall;
   logic                 start_cond;
   logic                 stop_cond;
   logic                 status_clear;
   logic                 ara_clear;
   logic                 oneshot_req;
   logic [4:0]           set_vec;
   logic [7:0]           rd_byte;
   logic [7:0]           new_remote;

   tms_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   ({scl_in, serial_data_pin_in}),
      .pin_sync (pins_sync)
   );
   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   function automatic logic ge_s(input logic [7:0] a, input logic [7:0] b);
      ge_s = $signed(a) >= $signed(b);
   endfunction

   function automatic logic wr_cmd(input logic [7:0] c);
      wr_cmd = (c >= tms_pkg::CMD_CFG_WR) && (c <= tms_pkg::CMD_RLO_WR);
   endfunction

   // reserved status bits and unused pointers read zero
   function automatic logic [7:0] rd_mux(input logic [7:0] c);
      case (c)
         tms_pkg::CMD_LOCAL:   rd_mux = local_temp_reading;
         tms_pkg::CMD_REMOTE:  rd_mux = remote_temp_reading;
         tms_pkg::CMD_STATUS:  rd_mux = {busy, flags, 2'h0};
         tms_pkg::CMD_CFG_RD:  rd_mux = {cfg_mask, standby, 6'h00};
         tms_pkg::CMD_RATE_RD: rd_mux = {5'h00, conv_rate};
         tms_pkg::CMD_LHI_RD:  rd_mux = lim.local_high;
         tms_pkg::CMD_LLO_RD:  rd_mux = lim.local_low;
         tms_pkg::CMD_RHI_RD:  rd_mux = lim.remote_high;
         tms_pkg::CMD_RLO_RD:  rd_mux = lim.remote_low;
         default:              rd_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      rise = scl_s && !scl_d;
      fall = !scl_s && scl_d;
      start_cond = scl_s && scl_d && sda_d && !sda_s;
      stop_cond = scl_s && scl_d && !sda_d && sda_s;
      next_state = state;
      next_after = after;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_tx = tx;
      next_is_ara = is_ara;
      next_send_ok = send_ok;
      next_cmd_ptr = cmd_ptr;
      next_cfg_mask = cfg_mask;
      next_standby = standby;
      next_conv_rate = conv_rate;
      next_lim = lim;
      next_sda_oe = serial_data_pin_oe;
      status_clear = 1'b0;
      ara_clear = 1'b0;
      oneshot_req = 1'b0;
      rd_byte = 8'h00;
      // serial slave, all four byte protocols share one walk
      if (start_cond) begin
         next_state = tms_pkg::ST_ADDR;
         // the scl fall that closes the start wraps this to zero, so it is not counted as a bit
         next_bit_cnt = tms_pkg::BIT_PRE;
         next_sda_oe = 1'b0;
         next_send_ok = 1'b0;
      end else if (stop_cond) begin
         // only a command with no data byte behind it converts
         oneshot_req = send_ok && (cmd_ptr == tms_pkg::CMD_ONESHOT);
         next_state = tms_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
         next_send_ok = 1'b0;
      end else if (state != tms_pkg::ST_IDLE) begin
         if (rise && (bit_cnt < tms_pkg::BIT_ACK)) begin
            next_shift = {shift[6:0], sda_s};
         end
         if (rise && (bit_cnt == tms_pkg::BIT_ACK) && (state == tms_pkg::ST_READ)) begin
            // a byte counts as read once its ninth clock arrives, acked or not
            if (is_ara) begin
               ara_clear = 1'b1;
            end else if (cmd_ptr == tms_pkg::CMD_STATUS) begin
               status_clear = 1'b1;
            end
            if (sda_s) begin
               next_state = tms_pkg::ST_IGNORE;
               next_after = tms_pkg::ST_IGNORE;
            end
         end
         if (fall) begin
            if (bit_cnt == tms_pkg::BIT_LAST) begin
               next_bit_cnt = tms_pkg::BIT_ACK;
               next_sda_oe = 1'b0;
               case (state)
                  tms_pkg::ST_ADDR: begin
                     if (shift[7:1] == DEV_ADDR) begin
                        next_sda_oe = 1'b1;
                        next_is_ara = 1'b0;
                        next_after = shift[0] ? tms_pkg::ST_READ : tms_pkg::ST_CMD;
                     end else if ((shift[7:1] == tms_pkg::ALERT_RESP_ADDR) && shift[0] && alert_latch) begin
                        next_sda_oe = 1'b1;
                        next_is_ara = 1'b1;
                        next_after = tms_pkg::ST_READ;
                     end else begin
                        next_after = tms_pkg::ST_IGNORE;
                     end
                  end
                  tms_pkg::ST_CMD: begin
                     next_sda_oe = 1'b1;
                     next_cmd_ptr = shift;
                     next_send_ok = 1'b1;
                     next_after = tms_pkg::ST_WDATA;
                  end
                  tms_pkg::ST_WDATA: begin
                     next_send_ok = 1'b0;
                     next_after = tms_pkg::ST_IGNORE;
                     // read-only codes, status among them, get a nack and no store
                     if (wr_cmd(cmd_ptr)) begin
                        next_sda_oe = 1'b1;
                        case (cmd_ptr)
                           tms_pkg::CMD_CFG_WR: begin
                              next_cfg_mask = shift[tms_pkg::CFG_MASK_BIT];
                              next_standby = shift[tms_pkg::CFG_STBY_BIT];
                           end
                           tms_pkg::CMD_RATE_WR: next_conv_rate = shift[2:0];
                           tms_pkg::CMD_LHI_WR:  next_lim.local_high = shift;
                           tms_pkg::CMD_LLO_WR:  next_lim.local_low = shift;
                           tms_pkg::CMD_RHI_WR:  next_lim.remote_high = shift;
                           default:              next_lim.remote_low = shift;
                        endcase
                     end
                  end
                  default: next_sda_oe = 1'b0;
               endcase
            end else if (bit_cnt == tms_pkg::BIT_ACK) begin
               next_bit_cnt = 4'h0;
               next_state = after;
               next_sda_oe = 1'b0;
               if (after == tms_pkg::ST_READ) begin
                  rd_byte = is_ara ? {DEV_ADDR, 1'b1} : rd_mux(cmd_ptr);
                  next_tx = rd_byte;
                  next_sda_oe = !rd_byte[7];
               end
            end else begin
               next_bit_cnt = bit_cnt + 4'h1;
               if (state == tms_pkg::ST_READ) begin
                  next_tx = {tx[6:0], 1'b0};
                  next_sda_oe = !tx[6];
               end
            end
         end
      end
   end

   always_comb begin
      next_busy = busy;
      next_cond = cond;
      next_fault_seen = fault_seen;
      next_fault_open = fault_open;
      next_local = local_temp_reading;
      next_remote = remote_temp_reading;
      set_vec = 5'h00;
      new_remote = conv.remote_temp;
      // a one-shot during a conversion is dropped, standby still allows one
      next_conv_start = !busy && !conv_start && (oneshot_req || (auto_tick && !standby));
      if (conv_start) begin
         next_busy = 1'b1;
         next_fault_seen = conv.diode_open || conv.diode_shorted;
         next_fault_open = conv.diode_open;
         if (conv.diode_open || conv.diode_shorted) begin
            next_remote = tms_pkg::TEMP_FAULT;
            set_vec[tms_pkg::FL_RHI] = 1'b1;
            set_vec[tms_pkg::FL_OPEN] = conv.diode_open;
            next_cond = cond | set_vec;
         end
      end else if (busy && conv_done) begin
         next_busy = 1'b0;
         new_remote = fault_seen ? tms_pkg::TEMP_FAULT : conv.remote_temp;
         next_local = conv.local_temp;
         next_remote = new_remote;
         set_vec[tms_pkg::FL_LHI] = ge_s(conv.local_temp, lim.local_high);
         set_vec[tms_pkg::FL_LLO] = ge_s(lim.local_low, conv.local_temp);
         set_vec[tms_pkg::FL_RHI] = ge_s(new_remote, lim.remote_high);
         set_vec[tms_pkg::FL_RLO] = ge_s(lim.remote_low, new_remote);
         set_vec[tms_pkg::FL_OPEN] = fault_open;
         next_cond = set_vec;
      end
      // set wins over the clear of a read in the same cycle
      next_flags = (status_clear ? cond : flags) | set_vec;
      next_alert_latch = (ara_clear ? |cond : alert_latch) | (|set_vec);
      next_alert_oe = next_alert_latch && !next_cfg_mask;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= tms_pkg::ST_IDLE;
         after <= tms_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         is_ara <= 1'b0;
         send_ok <= 1'b0;
         cmd_ptr <= tms_pkg::RST_PTR;
         cfg_mask <= 1'b0;
         standby <= 1'b0;
         conv_rate <= tms_pkg::RST_RATE;
         lim <= {tms_pkg::RST_HIGH, tms_pkg::RST_LOW, tms_pkg::RST_HIGH, tms_pkg::RST_LOW};
         local_temp_reading <= tms_pkg::RST_TEMP;
         remote_temp_reading <= tms_pkg::RST_TEMP;
         flags <= tms_pkg::RST_FLAGS;
         cond <= tms_pkg::RST_FLAGS;
         busy <= 1'b0;
         fault_seen <= 1'b0;
         fault_open <= 1'b0;
         alert_latch <= 1'b0;
         alert_n_oe <= 1'b0;
         alert_n_out <= 1'b0;
         serial_data_pin_oe <= 1'b0;
         serial_data_pin_out <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         state <= next_state;
         after <= next_after;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         tx <= next_tx;
         is_ara <= next_is_ara;
         send_ok <= next_send_ok;
         cmd_ptr <= next_cmd_ptr;
         cfg_mask <= next_cfg_mask;
         standby <= next_standby;
         conv_rate <= next_conv_rate;
         lim <= next_lim;
         local_temp_reading <= next_local;
         remote_temp_reading <= next_remote;
         flags <= next_flags;
         cond <= next_cond;
         busy <= next_busy;
         fault_seen <= next_fault_seen;
         fault_open <= next_fault_open;
         alert_latch <= next_alert_latch;
         alert_n_oe <= next_alert_oe;
         alert_n_out <= 1'b0;
         serial_data_pin_oe <= next_sda_oe;
         serial_data_pin_out <= 1'b0;
         conv_start <= next_conv_start;
      end
   end

   property p_status_nowrite;
      @(posedge core_clk) disable iff (!rst_n)
      (state == tms_pkg::ST_WDATA && fall && bit_cnt == tms_pkg::BIT_LAST && cmd_ptr == tms_pkg::CMD_STATUS)
         |=> !serial_data_pin_oe && (flags == ($past(flags) | $past(set_vec)));
   endproperty
   a_status_nowrite: assert property (p_status_nowrite) else $error("status write was not refused");

   property p_reset_flags;
      @(posedge core_clk) $rose(rst_n) |-> flags == 5'h00 && !alert_n_oe && cmd_ptr == 8'h00;
   endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("state wrong after reset");

   property p_read_clears;
      @(posedge core_clk) disable iff (!rst_n)
      status_clear && set_vec == 5'h00 |=> flags == $past(cond);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read did not clear to condition");

   property p_status_layout;
      @(posedge core_clk) disable iff (!rst_n)
      (state != tms_pkg::ST_IDLE && fall && bit_cnt == tms_pkg::BIT_ACK && after == tms_pkg::ST_READ
         && !is_ara && cmd_ptr == tms_pkg::CMD_STATUS)
         |=> tx == {$past(busy), $past(flags), 2'h0} && serial_data_pin_oe == !$past(busy);
   endproperty
   a_status_layout: assert property (p_status_layout) else $error("status byte layout wrong");

   property p_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      !status_clear |=> (flags & $past(flags)) == $past(flags);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without a read");

   property p_fault_alert;
      @(posedge core_clk) disable iff (!rst_n)
      (|set_vec) && !cfg_mask && !(state == tms_pkg::ST_WDATA) |=> alert_latch ##1 alert_n_oe || cfg_mask;
   endproperty
   a_fault_alert: assert property (p_fault_alert) else $error("fault did not raise alert");

   property p_alert_drive;
      @(posedge core_clk) disable iff (!rst_n)
      alert_n_oe == (alert_latch && !cfg_mask) && !alert_n_out;
   endproperty
   a_alert_drive: assert property (p_alert_drive) else $error("alert pin drive wrong");

   property p_alert_latched;
      @(posedge core_clk) disable iff (!rst_n)
      alert_latch && !ara_clear |=> alert_latch;
   endproperty
   a_alert_latched: assert property (p_alert_latched) else $error("alert cleared without alert response");

   property p_ara_release;
      @(posedge core_clk) disable iff (!rst_n)
      ara_clear && cond == 5'h00 && set_vec == 5'h00 |=> !alert_latch;
   endproperty
   a_ara_release: assert property (p_ara_release) else $error("alert not released by response");

   property p_diode_open;
      @(posedge core_clk) disable iff (!rst_n)
      conv_start && conv.diode_open |=> flags[tms_pkg::FL_OPEN] && flags[tms_pkg::FL_RHI] && alert_latch
         && remote_temp_reading == 8'h7f;
   endproperty
   a_diode_open: assert property (p_diode_open) else $error("open diode not flagged");

   property p_busy_hold;
      @(posedge core_clk) disable iff (!rst_n)
      conv_start |=> busy ##0 (busy && !conv_done) [*1] |=> busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before results stored");
endmodule // tms_top

// ---- tb/testbench.sv ----
// self-checking bench: register access, conversions, flags and alert response
`timescale 1ns/100ps
module testbench;
   localparam logic [6:0] ADR = tms_pkg::DEV_ADDR_DFLT;
   logic                  core_clk, rst_n, auto_tick, conv_done, conv_start, standby;
   logic                  sdo, sdo_oe, al_o, al_oe, scl, pull, nk;
   logic [2:0]            conv_rate;
   logic [3:0]            cnt;
   logic [7:0]            rd_data, v;
   logic [7:0]            exp_q[$];
   logic [7:0]            rv[7] = '{8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
   tms_pkg::tms_conv_t    conv;
   int                    err_total, samples_checked;
   wire                   sda = ~(pull | sdo_oe);
   tms_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .serial_data_pin_in(sda),
      .serial_data_pin_out(sdo), .serial_data_pin_oe(sdo_oe), .alert_n_out(al_o), .alert_n_oe(al_oe),
      .auto_tick(auto_tick), .conv_done(conv_done), .conv(conv), .conv_start(conv_start),
      .standby(standby), .conv_rate(conv_rate));
   tms_host i_host (.sda(sda), .scl(scl), .sda_pull(pull), .rd_data(rd_data));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // conversion engine stand-in: results a few cycles after each start
   always @(posedge core_clk) begin
      if (conv_start)
         cnt <= 4'h5;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      conv_done <= (cnt == 4'h1);
   end
   always @(i_host.rd_ev) chk(rd_data, exp_q.pop_front());
   task automatic rd(input logic [7:0] c, e, input logic [1:0] k);
      exp_q.push_back(e);
      i_host.txn(k == 2'd3 ? tms_pkg::ALERT_RESP_ADDR : ADR, c, 8'h00, k, nk);
   endtask
   // host waits out the conversion before touching status
   task automatic oneshot();
      i_host.txn(ADR, tms_pkg::CMD_ONESHOT, 8'h00, 2'd2, nk);
      repeat (30) @(posedge core_clk);
   endtask
   initial begin
      rst_n = 1'b0;
      auto_tick = 1'b0;
      conv = '0;
      cnt = 4'h0;
      err_total = 0;
      samples_checked = 0;
      void'($urandom(32'h4cb415d5));
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk(8'(conv_rate), 8'h02);
      chk(8'(al_oe), 8'h00);
      exp_q.push_back(tms_pkg::RST_TEMP);
      i_host.txn(ADR, 8'h00, 8'h00, 2'd3, nk);
      foreach (rv[i]) rd(8'h02 + 8'(i), rv[i], 2'd1);
      v = 8'h20 + 8'($urandom_range(15));
      i_host.txn(ADR, tms_pkg::CMD_STATUS, 8'h55, 2'd0, nk);
      chk(8'(nk), 8'h01);
      i_host.txn(7'h33, tms_pkg::CMD_LHI_WR, 8'h11, 2'd0, nk);
      chk(8'(nk), 8'h01);
      i_host.txn(ADR, tms_pkg::CMD_LHI_WR, v, 2'd0, nk);
      chk(8'(nk), 8'h00);
      rd(tms_pkg::CMD_LHI_RD, v, 2'd1);
      @(posedge core_clk) conv.local_temp <= v;
      oneshot();
      chk(8'(al_oe), 8'h01);
      rd(tms_pkg::CMD_STATUS, 8'h40, 2'd1);
      rd(tms_pkg::CMD_STATUS, 8'h40, 2'd1);
      @(posedge core_clk) conv.local_temp <= v - 8'h01;
      oneshot();
      rd(tms_pkg::CMD_STATUS, 8'h40, 2'd1);
      rd(tms_pkg::CMD_STATUS, 8'h00, 2'd1);
      chk(8'(al_oe), 8'h01);
      rd(8'h00, {ADR, 1'b1}, 2'd3);
      chk(8'(al_oe), 8'h00);
      // no alert pending, so nobody answers and the byte floats high
      exp_q.push_back(8'hff);
      i_host.txn(tms_pkg::ALERT_RESP_ADDR, 8'h00, 8'h00, 2'd3, nk);
      chk(8'(nk), 8'h01);
      @(posedge core_clk) conv.diode_open <= 1'b1;
      auto_tick <= 1'b1;
      @(posedge core_clk) auto_tick <= 1'b0;
      repeat (30) @(posedge core_clk);
      rd(tms_pkg::CMD_STATUS, 8'h14, 2'd1);
      rd(tms_pkg::CMD_REMOTE, tms_pkg::TEMP_FAULT, 2'd1);
      // shorted diode: open flag sticks until read, then only the high trip remains
      @(posedge core_clk) {conv.diode_open, conv.diode_shorted} <= 2'h1;
      auto_tick <= 1'b1;
      @(posedge core_clk) auto_tick <= 1'b0;
      repeat (30) @(posedge core_clk);
      rd(tms_pkg::CMD_STATUS, 8'h14, 2'd1);
      rd(tms_pkg::CMD_STATUS, 8'h10, 2'd1);
      chk(8'(al_oe), 8'h01);
      i_host.txn(ADR, tms_pkg::CMD_CFG_WR, 8'hc0, 2'd0, nk);
      repeat (2) @(posedge core_clk);
      chk(8'({al_oe, standby, sdo, al_o}), 8'h04);
      conclude();
   end
   initial begin
      #3000000;
      err_total++;
      conclude();
   end
endmodule // testbench

// ---- tb/tms_host.sv ----
// host controller model: byte transactions on the serial pins
`timescale 1ns/100ps
module tms_host (
   // bus levels, data line pulled up outside
   input  wire logic       sda,
   output logic            scl,
   output logic            sda_pull,
   // last byte read back
   output logic [7:0]      rd_data
);
   event rd_ev;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_data = 8'h00;
   end
   // data moves mid-low so both pins stay apart at the synchroniser
   task automatic start();
      #200 sda_pull <= 1'b0;
      #200 scl <= 1'b1;
      #200 sda_pull <= 1'b1;
      #200 scl <= 1'b0;
   endtask
   task automatic stop();
      #200 sda_pull <= 1'b1;
      #200 scl <= 1'b1;
      #200 sda_pull <= 1'b0;
      #400;
   endtask
   // eight bits msb first, ninth released and sampled
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, inout logic nk);
      logic ak;
      for (int i = 8; i >= 0; i--) begin
         #200 sda_pull <= (i > 0) ? ~tx[i-1] : 1'b0;
         #200 scl <= 1'b1;
         #200 ak = sda;
         if (i > 0)
            rx[i-1] = ak;
         #200 scl <= 1'b0;
      end
      nk = nk | ak;
   endtask
   // k: 0 write byte, 1 read byte, 2 send byte, 3 receive byte
   task automatic txn(input logic [6:0] a, input logic [7:0] c, d, input logic [1:0] k, output logic nk);
      logic [7:0] rx;
      logic       dn;
      nk = 1'b0;
      start();
      if (k != 2'd3) begin
         xfer({a, 1'b0}, rx, nk);
         xfer(c, rx, nk);
      end
      if (k == 2'd0)
         xfer(d, rx, nk);
      if (k[0]) begin
         if (k == 2'd1)
            start();
         xfer({a, 1'b1}, rx, nk);
         xfer(8'hff, rx, dn);
         rd_data = rx;
         -> rd_ev;
      end
      stop();
   endtask
endmodule // tms_host
